// [pkg/tws_pkg.sv]
// constants, types and register map of the two-wire configuration slave
package tws_pkg;

  // slave address: fixed upper nibble, strap pins give the low three bits
  localparam logic [3:0] OWN_ADDR_HIGH = 4'ha;
  localparam logic       DIR_WRITE     = 1'b0;
  localparam logic       DIR_READ      = 1'b1;

  // register offsets
  localparam logic [7:0] REG_OUTER = 8'h00;
  localparam logic [7:0] REG_INNER = 8'h01;
  localparam logic [7:0] REG_STAT  = 8'h02;
  localparam logic [7:0] REG_LAST  = 8'h02;

  // reset values and writable bits
  localparam logic [7:0] OUTER_RESET   = 8'h00;
  localparam logic [7:0] INNER_RESET   = 8'h00;
  localparam logic [7:0] STAT_RESET    = 8'hdc;
  localparam logic [7:0] DRIVE_WR_MASK = 8'h7f;

  // field positions
  localparam int CODE_LSB     = 0;
  localparam int CODE_MSB     = 3;
  localparam int STAT_B_LSB   = 4;
  localparam int STAT_A_LSB   = 0;
  localparam int CFG_WIDTH    = 4;

  // strap mode drive codes
  localparam logic [3:0] INNER_BASE_CODE = 4'h0;
  localparam logic       STRAP_CODE_LSB  = 1'b0;

  // bit counting on the link
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] ACK_SLOT = 4'h8;
  localparam logic [2:0] RD_FIRST = 3'h7;
  localparam logic [2:0] RD_DONE  = 3'h0;

  // status source selection codes
  localparam logic [1:0] SRC_HS         = 2'h0;
  localparam logic [1:0] SRC_HOST_OUTER = 2'h1;
  localparam logic [1:0] SRC_STATE0     = 2'h2;
  localparam logic [1:0] SRC_STATE1     = 2'h3;

  typedef struct packed {
    logic       hs;
    logic       host_outer;
    logic [1:0] state;
  } tws_status_t;

  typedef struct packed {
    logic       open_drain;
    logic       invert;
    logic [1:0] source;
  } tws_pincfg_t;

  typedef struct packed {
    logic level;
    logic oe_n;
  } tws_pin_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_REGISTER_ADDRESS_BYTE,
    ST_DATA,
    ST_ACK_WAIT,
    ST_ACK_DRIVE,
    ST_READ,
    ST_SKIP
  } tws_state_t;

endpackage

// [rtl/tws_link_rx.sv]
// link-clock byte receiver: shifts sda on scl rising edges
`timescale 1ns/1ns
module tws_link_rx (
  input  wire logic       scl_clk,
  input  wire logic       arst_n,
  input  wire logic       frame_clear,
  input  wire logic       sda,
  output logic [7:0]      byte_hold,
  output logic            byte_tgl
);
  import tws_pkg::*;

  logic       frame_rst_n;
  logic [3:0] bit_cnt;
  logic [3:0] next_bit_cnt;
  logic [7:0] shift;
  logic [7:0] next_shift;
  logic [7:0] next_byte_hold;
  logic       next_byte_tgl;

  // counter restarts at each start; released while scl is low, well before the first rise
  assign frame_rst_n = arst_n & ~frame_clear;

  always_comb begin
    next_shift     = {shift[6:0], sda};
    next_byte_hold = byte_hold;
    next_byte_tgl  = byte_tgl;
    if (bit_cnt == ACK_SLOT) begin
      next_bit_cnt = 4'h0;
    end else begin
      next_bit_cnt = bit_cnt + 4'h1;
    end
    if (bit_cnt == BIT_LAST) begin
      next_byte_hold = {shift[6:0], sda};
      next_byte_tgl  = ~byte_tgl;
    end
  end

  always_ff @(posedge scl_clk or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      bit_cnt <= 4'h0;
      shift   <= 8'h00;
    end else begin
      bit_cnt <= next_bit_cnt;
      shift   <= next_shift;
    end
  end

  // the toggle survives frame clears so the far side never sees a false event
  always_ff @(posedge scl_clk or negedge arst_n) begin
    if (!arst_n) begin
      byte_hold <= 8'h00;
      byte_tgl  <= 1'b0;
    end else begin
      byte_hold <= next_byte_hold;
      byte_tgl  <= next_byte_tgl;
    end
  end

endmodule

// [rtl/tws_config_slave.sv]
// two-wire configuration slave with drive-code and status-pin logic
`timescale 1ns/1ns
module tws_config_slave (
  input  wire logic                 REF_CLK,
  input  wire logic                 ARST_N,
  input  wire logic                 SCL_CLK,
  input  wire logic                 SDA_IN,
  output logic                      SDA_OUT,
  output logic                      SDA_OE_N,
  input  wire logic                 SEL_I2C,
  input  wire logic                 STRAP_PIN_2,
  input  wire logic                 STRAP_PIN_1,
  input  wire logic                 STRAP_PIN_0,
  input  wire tws_pkg::tws_status_t STATUS,
  output logic [3:0]                OUTER_DRIVE_CODE,
  output logic [3:0]                INNER_DRIVE_CODE,
  output logic                      STATUS_PIN_A_OUT,
  output logic                      STATUS_PIN_A_OE_N,
  output logic                      STATUS_PIN_B_OUT,
  output logic                      STATUS_PIN_B_OE_N
);
  import tws_pkg::*;

  // pick the status bit named by a source code
  function automatic logic src_pick(input logic [1:0] source, input tws_status_t st);
    logic bit_val;
    case (source)
      SRC_HS:         bit_val = st.hs;
      SRC_HOST_OUTER: bit_val = st.host_outer;
      SRC_STATE0:     bit_val = st.state[0];
      default:        bit_val = st.state[1];
    endcase
    return bit_val;
  endfunction

  // level and enable for one status pin
  function automatic tws_pin_t pin_drive(input tws_pincfg_t cfg, input tws_status_t st);
    tws_pin_t pin;
    logic     value;
    value = src_pick(cfg.source, st) ^ cfg.invert;
    if (cfg.open_drain) begin
      pin.level = 1'b0;
      pin.oe_n  = value;
    end else begin
      pin.level = value;
      pin.oe_n  = 1'b0;
    end
    return pin;
  endfunction

  // register read view, bit7 of the drive registers reads zero
  function automatic logic [7:0] read_reg(input logic [7:0] ptr, input logic [7:0] outer,
                                          input logic [7:0] inner, input logic [7:0] stat);
    logic [7:0] data;
    case (ptr)
      REG_OUTER: data = outer & DRIVE_WR_MASK;
      REG_INNER: data = inner & DRIVE_WR_MASK;
      REG_STAT:  data = stat;
      default:   data = 8'h00;
    endcase
    return data;
  endfunction

  // synchronisers
  logic       scl_meta, scl_s, scl_d;
  logic       sda_meta, sda_s, sda_d;
  logic       sel_meta, sel_s;
  logic [2:0] strap_meta, strap_s;
  logic       tgl_meta, tgl_s, tgl_d;

  // link receiver
  logic [7:0] byte_hold;
  logic       byte_tgl;

  // engine state
  tws_state_t state, next_state;
  tws_state_t after_state, next_after_state;
  logic       ack_ok, next_ack_ok;
  logic       do_write, next_do_write;
  logic [7:0] byte_in, next_byte_in;
  logic [7:0] reg_ptr, next_reg_ptr;
  logic [7:0] rd_shift, next_rd_shift;
  logic [2:0] rd_cnt, next_rd_cnt;
  logic       sda_low, next_sda_low;
  logic       frame_clear, next_frame_clear;

  // registers and outputs
  logic [7:0] outer_port_drive_level, next_outer_port_drive_level;
  logic [7:0] inner_port_drive_level, next_inner_port_drive_level;
  logic [7:0] status_pin_config, next_status_pin_config;
  logic [3:0] next_outer_code, next_inner_code;
  tws_pin_t   pin_a, pin_b, next_pin_a, next_pin_b;
  logic [7:0] cfg_used;

  logic scl_fall, start_evt, stop_evt, byte_evt, wr_commit;

  // two flops on scl, sda, select and strap before the engine sees them; STATUS and the link receiver skip them
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      scl_meta   <= 1'b1;
      scl_s      <= 1'b1;
      scl_d      <= 1'b1;
      sda_meta   <= 1'b1;
      sda_s      <= 1'b1;
      sda_d      <= 1'b1;
      sel_meta   <= 1'b0;
      sel_s      <= 1'b0;
      strap_meta <= 3'h0;
      strap_s    <= 3'h0;
      tgl_meta   <= 1'b0;
      tgl_s      <= 1'b0;
      tgl_d      <= 1'b0;
    end else begin
      scl_meta   <= SCL_CLK;
      scl_s      <= scl_meta;
      scl_d      <= scl_s;
      sda_meta   <= SDA_IN;
      sda_s      <= sda_meta;
      sda_d      <= sda_s;
      sel_meta   <= SEL_I2C;
      sel_s      <= sel_meta;
      strap_meta <= {STRAP_PIN_2, STRAP_PIN_1, STRAP_PIN_0};
      strap_s    <= strap_meta;
      tgl_meta   <= byte_tgl;
      tgl_s      <= tgl_meta;
      tgl_d      <= tgl_s;
    end
  end

  tws_link_rx u_link_rx (
    .scl_clk     (SCL_CLK),
    .arst_n      (ARST_N),
    .frame_clear (frame_clear),
    .sda         (SDA_IN),
    .byte_hold   (byte_hold),
    .byte_tgl    (byte_tgl)
  );

  // oversampling at the reference clock keeps fast-mode edges well resolved
  // standard and fast rates
  assign scl_fall  = scl_d & ~scl_s;
  assign start_evt = scl_s & scl_d & sda_d & ~sda_s;
  assign stop_evt  = scl_s & scl_d & ~sda_d & sda_s;
  assign byte_evt  = tgl_s ^ tgl_d;

  always_comb begin
    next_state       = state;
    next_after_state = after_state;
    next_ack_ok      = ack_ok;
    next_do_write    = do_write;
    next_byte_in     = byte_in;
    next_reg_ptr     = reg_ptr;
    next_rd_shift    = rd_shift;
    next_rd_cnt      = rd_cnt;
    next_sda_low     = sda_low;
    next_frame_clear = frame_clear;
    if (scl_fall) begin
      next_frame_clear = 1'b0;
    end
    if (stop_evt) begin
      next_state       = ST_IDLE;
      next_sda_low     = 1'b0;
      next_do_write    = 1'b0;
      next_frame_clear = 1'b1;
    end else if (start_evt) begin
      // a repeated start is treated like a fresh one
      next_state       = ST_ADDR;
      next_sda_low     = 1'b0;
      next_do_write    = 1'b0;
      next_frame_clear = 1'b1;
    end else begin
      case (state)
        ST_IDLE: begin
          next_frame_clear = 1'b1;
        end
        ST_ADDR: begin
          if (byte_evt) begin
            next_byte_in = byte_hold;
            next_ack_ok      = sel_s && (byte_hold[7:1] == {OWN_ADDR_HIGH, strap_s});
            next_after_state = (byte_hold[0] == DIR_READ) ? ST_READ : ST_REGISTER_ADDRESS_BYTE;
            next_state       = ST_ACK_WAIT;
          end
        end
        ST_REGISTER_ADDRESS_BYTE: begin
          if (byte_evt) begin
            next_byte_in = byte_hold;
            next_ack_ok = byte_hold <= REG_LAST;
            if (byte_hold <= REG_LAST) begin
              next_reg_ptr = byte_hold;
            end
            next_after_state = ST_DATA;
            next_state       = ST_ACK_WAIT;
          end
        end
        ST_DATA: begin
          if (byte_evt) begin
            next_byte_in     = byte_hold;
            next_ack_ok      = 1'b1;
            next_do_write    = 1'b1;
            next_after_state = ST_SKIP;
            next_state       = ST_ACK_WAIT;
          end
        end
        ST_ACK_WAIT: begin
          if (scl_fall) begin
            next_sda_low = ack_ok;
            next_state   = ack_ok ? ST_ACK_DRIVE : ST_SKIP;
          end
        end
        ST_ACK_DRIVE: begin
          if (scl_fall) begin
            next_do_write = 1'b0;
            next_state    = after_state;
            next_sda_low  = 1'b0;
            if (after_state == ST_READ) begin
              next_rd_shift = {read_reg(reg_ptr, outer_port_drive_level,
                                        inner_port_drive_level, status_pin_config)};
              next_sda_low  = ~next_rd_shift[7];
              next_rd_shift = {next_rd_shift[6:0], 1'b0};
              next_rd_cnt   = RD_FIRST;
            end
          end
        end
        ST_READ: begin
          if (scl_fall) begin
            // slot after the last bit is left to the master
            if (rd_cnt == RD_DONE) begin
              next_sda_low = 1'b0;
              next_state   = ST_SKIP;
            end else begin
              next_sda_low  = ~rd_shift[7];
              next_rd_shift = {rd_shift[6:0], 1'b0};
              next_rd_cnt   = rd_cnt - 3'h1;
            end
          end
        end
        ST_SKIP: begin
          next_sda_low = 1'b0;
        end
        default: begin
          next_state   = ST_IDLE;
          next_sda_low = 1'b0;
        end
      endcase
    end
  end

  // pointer survives stop, only reset clears it
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      state       <= ST_IDLE;
      after_state <= ST_IDLE;
      ack_ok      <= 1'b0;
      do_write    <= 1'b0;
      byte_in     <= 8'h00;
      reg_ptr     <= REG_OUTER;
      rd_shift    <= 8'h00;
      rd_cnt      <= RD_DONE;
      sda_low     <= 1'b0;
      frame_clear <= 1'b1;
    end else begin
      state       <= next_state;
      after_state <= next_after_state;
      ack_ok      <= next_ack_ok;
      do_write    <= next_do_write;
      byte_in     <= next_byte_in;
      reg_ptr     <= next_reg_ptr;
      rd_shift    <= next_rd_shift;
      rd_cnt      <= next_rd_cnt;
      sda_low     <= next_sda_low;
      frame_clear <= next_frame_clear;
    end
  end

  // commit once the ack slot ends
  assign wr_commit = (state == ST_ACK_DRIVE) && scl_fall && do_write && !stop_evt
                     && !start_evt && sel_s;

  always_comb begin
    next_outer_port_drive_level = outer_port_drive_level;
    next_inner_port_drive_level = inner_port_drive_level;
    next_status_pin_config      = status_pin_config;
    if (wr_commit) begin
      case (reg_ptr)
        REG_OUTER: next_outer_port_drive_level = byte_in & DRIVE_WR_MASK;
        REG_INNER: next_inner_port_drive_level = byte_in & DRIVE_WR_MASK;
        REG_STAT:  next_status_pin_config = byte_in;
        default:   next_status_pin_config = status_pin_config;
      endcase
    end
  end

  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      outer_port_drive_level <= OUTER_RESET;
      inner_port_drive_level <= INNER_RESET;
      status_pin_config      <= STAT_RESET;
    end else begin
      outer_port_drive_level <= next_outer_port_drive_level;
      inner_port_drive_level <= next_inner_port_drive_level;
      status_pin_config      <= next_status_pin_config;
    end
  end

  // strap mode behaves like the pin-config reset value
  assign cfg_used = sel_s ? status_pin_config : STAT_RESET;

  always_comb begin
    if (sel_s) begin
      next_outer_code = outer_port_drive_level[CODE_MSB:CODE_LSB];
      next_inner_code = inner_port_drive_level[CODE_MSB:CODE_LSB];
    end else begin
      next_outer_code = {strap_s, STRAP_CODE_LSB};
      next_inner_code = INNER_BASE_CODE;
    end
    next_pin_b = pin_drive(tws_pincfg_t'(cfg_used[STAT_B_LSB +: CFG_WIDTH]), STATUS);
    next_pin_a = pin_drive(tws_pincfg_t'(cfg_used[STAT_A_LSB +: CFG_WIDTH]), STATUS);
  end

  // open-drain idle is released so nothing is driven during reset
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      OUTER_DRIVE_CODE <= INNER_BASE_CODE;
      INNER_DRIVE_CODE <= INNER_BASE_CODE;
      pin_a            <= '{level: 1'b0, oe_n: 1'b1};
      pin_b            <= '{level: 1'b0, oe_n: 1'b1};
    end else begin
      OUTER_DRIVE_CODE <= next_outer_code;
      INNER_DRIVE_CODE <= next_inner_code;
      pin_a            <= next_pin_a;
      pin_b            <= next_pin_b;
    end
  end

  assign STATUS_PIN_A_OUT  = pin_a.level;
  assign STATUS_PIN_A_OE_N = pin_a.oe_n;
  assign STATUS_PIN_B_OUT  = pin_b.level;
  assign STATUS_PIN_B_OE_N = pin_b.oe_n;
  assign SDA_OUT           = 1'b0;
  assign SDA_OE_N          = ~sda_low;

endmodule

// [testbench/tws_i2c_master_model.sv]
// two-wire bus master model driving clock and data toward the slave
`timescale 1ns/1ns
module tws_i2c_master_model (
  output logic      scl,
  output logic      sda_drv,
  input  wire logic sda
);
  // fast-mode timing: low 1300 ns, high 600 ns
  localparam int QLOW  = 650;
  localparam int QHIGH = 300;

  // clock stands high and data is released between frames
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end

  // data moves only while the clock is low, sampled mid high phase
  task automatic clk_bit(input logic d, output logic s);
    #QLOW sda_drv = d;
    #QLOW scl = 1'b1;
    #QHIGH s = sda;
    #QHIGH scl = 1'b0;
  endtask

  // start issued only from an idle bus, never repeated
  task automatic start_cond();
    #QLOW sda_drv = 1'b0;
    #QLOW scl = 1'b0;
  endtask

  task automatic stop_cond();
    #QLOW sda_drv = 1'b0;
    #QLOW scl = 1'b1;
    #QLOW sda_drv = 1'b1;
    #QLOW;
  endtask

  // seven-bit address byte or data, msb first
  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(b[i], s);
    end
    clk_bit(1'b1, s);
    ack = ~s;
  endtask

  // master answers the read byte with ack or nak
  task automatic read_byte(input logic mack, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(1'b1, b[i]);
    end
    clk_bit(~mack, s);
  endtask
endmodule

// [testbench/tws_config_slave_checker.sv]
// port-level assertions for the two-wire configuration slave
`timescale 1ns/1ns
module tws_config_slave_checker (
  input wire logic                 REF_CLK,
  input wire logic                 ARST_N,
  input wire logic                 SCL_CLK,
  input wire logic                 SDA_IN,
  input wire logic                 SDA_OUT,
  input wire logic                 SDA_OE_N,
  input wire logic                 SEL_I2C,
  input wire logic                 STRAP_PIN_2,
  input wire logic                 STRAP_PIN_1,
  input wire logic                 STRAP_PIN_0,
  input wire tws_pkg::tws_status_t STATUS,
  input wire logic [3:0]           OUTER_DRIVE_CODE,
  input wire logic [3:0]           INNER_DRIVE_CODE,
  input wire logic                 STATUS_PIN_A_OUT,
  input wire logic                 STATUS_PIN_A_OE_N,
  input wire logic                 STATUS_PIN_B_OUT,
  input wire logic                 STATUS_PIN_B_OE_N
);
  import tws_pkg::*;
  logic [2:0] straps;
  assign straps = {STRAP_PIN_2, STRAP_PIN_1, STRAP_PIN_0};
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!ARST_N);

  // five edges cover the two-flop synchroniser plus the output register
  sequence s_strap_held;
    (!SEL_I2C && $stable(straps)) [*5];
  endsequence
  sequence s_pull_held;
    !SDA_OE_N [*8];
  endsequence

  property p_strap_outer; s_strap_held |-> OUTER_DRIVE_CODE == {straps, 1'b0}; endproperty
  a_strap_outer: assert property (p_strap_outer) else $error("outer code not strap");
  property p_strap_inner; s_strap_held |-> INNER_DRIVE_CODE == 4'h0; endproperty
  a_strap_inner: assert property (p_strap_inner) else $error("inner code not base");
  property p_strap_pin_a;
    s_strap_held |-> !STATUS_PIN_A_OUT && STATUS_PIN_A_OE_N == !$past(STATUS.hs);
  endproperty
  a_strap_pin_a: assert property (p_strap_pin_a) else $error("pin a strap level");
  property p_strap_pin_b;
    s_strap_held |-> !STATUS_PIN_B_OUT && STATUS_PIN_B_OE_N == !$past(STATUS.host_outer);
  endproperty
  a_strap_pin_b: assert property (p_strap_pin_b) else $error("pin b strap level");
  property p_sda_low_only; SDA_OUT == 1'b0; endproperty
  a_sda_low_only: assert property (p_sda_low_only) else $error("sda driven high");
  property p_quiet_strap; !SEL_I2C [*8] |-> SDA_OE_N; endproperty
  a_quiet_strap: assert property (p_quiet_strap) else $error("sda pulled in strap mode");
  property p_sda_move_low; $changed(SDA_OE_N) |-> !SCL_CLK; endproperty
  a_sda_move_low: assert property (p_sda_move_low) else $error("sda moved, scl high");
  property p_ack_stands; $fell(SDA_OE_N) |=> s_pull_held; endproperty
  a_ack_stands: assert property (p_ack_stands) else $error("sda pull too short");
  property p_reset_out;
    $rose(ARST_N) |-> OUTER_DRIVE_CODE == 4'h0 && INNER_DRIVE_CODE == 4'h0 && SDA_OE_N
      && STATUS_PIN_A_OE_N && STATUS_PIN_B_OE_N;
  endproperty
  a_reset_out: assert property (p_reset_out) else $error("outputs not reset");
  property p_od_levels;
    (STATUS_PIN_A_OUT -> !STATUS_PIN_A_OE_N) && (STATUS_PIN_B_OUT -> !STATUS_PIN_B_OE_N);
  endproperty
  a_od_levels: assert property (p_od_levels) else $error("status pin high, floating");
endmodule

bind tws_config_slave tws_config_slave_checker u_checker (
  .REF_CLK(REF_CLK), .ARST_N(ARST_N), .SCL_CLK(SCL_CLK), .SDA_IN(SDA_IN),
  .SDA_OUT(SDA_OUT), .SDA_OE_N(SDA_OE_N), .SEL_I2C(SEL_I2C), .STRAP_PIN_2(STRAP_PIN_2),
  .STRAP_PIN_1(STRAP_PIN_1), .STRAP_PIN_0(STRAP_PIN_0), .STATUS(STATUS),
  .OUTER_DRIVE_CODE(OUTER_DRIVE_CODE), .INNER_DRIVE_CODE(INNER_DRIVE_CODE),
  .STATUS_PIN_A_OUT(STATUS_PIN_A_OUT), .STATUS_PIN_A_OE_N(STATUS_PIN_A_OE_N),
  .STATUS_PIN_B_OUT(STATUS_PIN_B_OUT), .STATUS_PIN_B_OE_N(STATUS_PIN_B_OE_N)
);

// [testbench/tws_config_slave_test.sv]
// self-checking bench for the two-wire configuration slave
`timescale 1ns/1ns
`define CHK(nm, exp, got) begin check_count++; if ((got) !== (exp)) begin miscompares++; \
  $display("MISMATCH %s expected %h seen %h", nm, exp, got); end end
module tws_config_slave_test;
  import tws_pkg::*;
  logic        ref_clk;
  logic        arst_n;
  logic        sel_i2c;
  logic [2:0]  strap;
  tws_status_t status;
  logic        scl;
  logic        m_sda_drv;
  logic        sda;
  logic        sda_out;
  logic        sda_oe_n;
  logic [3:0]  outer_code;
  logic [3:0]  inner_code;
  logic [1:0]  pin_a;
  logic [1:0]  pin_b;
  int          miscompares = 0;
  int          check_count = 0;

  // open-drain wire with pull-up
  assign sda = m_sda_drv & (sda_oe_n | sda_out);

  tws_i2c_master_model u_master (.scl(scl), .sda_drv(m_sda_drv), .sda(sda));

  tws_config_slave DUT (
    .REF_CLK(ref_clk), .ARST_N(arst_n), .SCL_CLK(scl), .SDA_IN(sda), .SDA_OUT(sda_out),
    .SDA_OE_N(sda_oe_n), .SEL_I2C(sel_i2c), .STRAP_PIN_2(strap[2]), .STRAP_PIN_1(strap[1]),
    .STRAP_PIN_0(strap[0]), .STATUS(status), .OUTER_DRIVE_CODE(outer_code),
    .INNER_DRIVE_CODE(inner_code), .STATUS_PIN_A_OUT(pin_a[1]), .STATUS_PIN_A_OE_N(pin_a[0]),
    .STATUS_PIN_B_OUT(pin_b[1]), .STATUS_PIN_B_OE_N(pin_b[0])
  );

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // source pick, invert then push-pull or open drain; returns {out, oe_n}
  function automatic logic [1:0] pin_exp(input logic [3:0] c, input logic [3:0] s);
    logic v;
    v = (c[1] ? s[{1'b0, c[0]}] : s[{1'b1, ~c[0]}]) ^ c[2];
    return c[3] ? {1'b0, v} : {v, 1'b0};
  endfunction

  // write frame; the master stops early once a byte is refused
  task automatic wr(input logic [6:0] a, input logic [7:0] r, input logic [7:0] d,
                    input int n, input logic [2:0] exp);
    logic [2:0] ack;
    ack = 3'h0;
    u_master.start_cond();
    u_master.send_byte({a, 1'b0}, ack[0]);
    if (ack[0]) u_master.send_byte(r, ack[1]);
    if (ack[1] && n > 2) u_master.send_byte(d, ack[2]);
    u_master.stop_cond();
    `CHK("ack pattern", exp, ack)
  endtask

  // read frame at the kept register pointer
  task automatic rd(input logic [6:0] a, input logic [7:0] exp);
    logic       ack;
    logic [7:0] got;
    u_master.start_cond();
    u_master.send_byte({a, 1'b1}, ack);
    u_master.read_byte(1'b0, got);
    u_master.stop_cond();
    `CHK("read ack", 1'b1, ack)
    `CHK("read data", exp, got)
  endtask

  task automatic rdp(input logic [6:0] a, input logic [7:0] r, input logic [7:0] exp);
    wr(a, r, 8'h00, 2, 3'b011);
    rd(a, exp);
  endtask

  // one cycle from status input to the registered pins
  task automatic chk_pins(input logic [7:0] cfg);
    for (int s = 0; s < 16; s++) begin
      @(negedge ref_clk);
      status = tws_status_t'(4'(s));
      @(negedge ref_clk);
      `CHK("pin a", pin_exp(cfg[3:0], 4'(s)), pin_a)
      `CHK("pin b", pin_exp(cfg[7:4], 4'(s)), pin_b)
    end
  endtask

  task automatic t_reset_values();
    `CHK("outer code", 4'h0, outer_code)
    rdp(7'h50, 8'h00, 8'h00);
    rdp(7'h50, 8'h01, 8'h00);
    rdp(7'h50, 8'h02, 8'hdc);
    chk_pins(8'hdc);
    $display("test reset_values done");
  endtask

  // bit7 is read-only, reserved bits kept at zero, codes within advice
  task automatic t_write_read();
    wr(7'h50, 8'h00, 8'h85, 3, 3'b111);
    rd(7'h50, 8'h05);
    `CHK("outer code", 4'h5, outer_code)
    wr(7'h50, 8'h01, 8'h02, 3, 3'b111);
    rd(7'h50, 8'h02);
    `CHK("inner code", 4'h2, inner_code)
    $display("test write_read done");
  endtask

  task automatic t_refused();
    wr(7'h51, 8'h00, 8'h0f, 3, 3'b000);
    wr(7'h50, 8'h03, 8'h0f, 3, 3'b001);
    rd(7'h50, 8'h02);
    `CHK("outer code", 4'h5, outer_code)
    $display("test refused done");
  endtask

  task automatic t_status_pins();
    wr(7'h50, 8'h02, 8'h27, 3, 3'b111);
    chk_pins(8'h27);
    wr(7'h50, 8'h02, 8'h9d, 3, 3'b111);
    chk_pins(8'h9d);
    $display("test status_pins done");
  endtask

  task automatic t_strap_mode();
    @(negedge ref_clk);
    sel_i2c = 1'b0;
    strap = 3'b101;
    repeat (8) @(negedge ref_clk);
    `CHK("outer code", 4'ha, outer_code)
    `CHK("inner code", 4'h0, inner_code)
    chk_pins(8'hdc);
    wr(7'h55, 8'h00, 8'h06, 3, 3'b000);
    @(negedge ref_clk);
    sel_i2c = 1'b1;
    repeat (8) @(negedge ref_clk);
    `CHK("inner code", 4'h2, inner_code)
    `CHK("outer code", 4'h5, outer_code)
    wr(7'h55, 8'h00, 8'h06, 3, 3'b111);
    `CHK("outer code", 4'h6, outer_code)
    wr(7'h50, 8'h00, 8'h00, 3, 3'b000);
    $display("test strap_mode done");
  endtask

  task automatic t_mid_reset();
    @(negedge ref_clk);
    arst_n = 1'b0;
    repeat (4) @(negedge ref_clk);
    `CHK("outer code", 4'h0, outer_code)
    `CHK("sda pull", 1'b1, sda_oe_n)
    arst_n = 1'b1;
    repeat (10) @(negedge ref_clk);
    rdp(7'h55, 8'h00, 8'h00);
    chk_pins(8'hdc);
    $display("test mid_reset done");
  endtask

  // a hang shows up as one mismatch
  initial begin
    repeat (100000) @(posedge ref_clk);
    `CHK("run time", 1'b0, 1'b1)
    tally_and_finish();
  end

  initial begin
    arst_n = 1'b0;
    sel_i2c = 1'b1;
    strap = 3'h0;
    status = '0;
    repeat (4) @(negedge ref_clk);
    arst_n = 1'b1;
    repeat (10) @(negedge ref_clk);
    t_reset_values();
    t_write_read();
    t_refused();
    t_status_pins();
    t_strap_mode();
    t_mid_reset();
    tally_and_finish();
  end
endmodule
